// ===== pkg/srts_defs.svh
// Constants for the residual time stamp block: offsets, fields, counts.
`ifndef SRTS_DEFS_SVH
`define SRTS_DEFS_SVH

// Register bus address width and register byte offsets.
`define SRTS_AW 5
`define SRTS_OFF_CTRL 5'h00
`define SRTS_OFF_STATUS 5'h04
`define SRTS_OFF_AVG 5'h08
`define SRTS_OFF_OBS 5'h0C

// Control register fields.
`define SRTS_C_SDT 0
`define SRTS_C_CAS 1
`define SRTS_C_SRC 2
`define SRTS_C_ADP 4
`define SRTS_C_N 5
`define SRTS_CTRL_W 11
`define SRTS_CTRL_RST 11'h000

// Status register fields.
`define SRTS_S_TXOVF 0
`define SRTS_S_TXUNF 1
`define SRTS_S_RXOVF 2
`define SRTS_S_RXUNF 3
`define SRTS_S_HOLD 4
`define SRTS_STS_W 4

// Terminal counts: 3008 - 1 and 3000 - 1 payload bits per time stamp period.
`define SRTS_LIM_UDT 12'hBBF
`define SRTS_LIM_SDT 12'hBB7

// Timestamp FIFO geometry.
`define SRTS_DEPTH 4
`define SRTS_PW 2
`define SRTS_CNT_FULL 3'h4

// Response codes.
`define SRTS_RESP_OKAY 2'h0
`define SRTS_RESP_SLVERR 2'h2

`endif

// ===== pkg/srts_pkg.sv
// Types shared by the residual time stamp block.
`default_nettype none
package srts_pkg;
  typedef enum logic [1:0] {
    SRTS_SRC_LINE = 2'h0,
    SRTS_SRC_PLL = 2'h1,
    SRTS_SRC_BP = 2'h3
  } srts_src_e;
  typedef logic [4:0] srts_ent_t;
  typedef logic [15:0] srts_phase_t;
endpackage : srts_pkg
`default_nettype wire

// ===== pkg/srts_fifo_if.sv
// Carrier between the timestamp core and its FIFOs.
`default_nettype none
interface srts_fifo_if;
  import srts_pkg::*;
  logic wr;
  srts_ent_t wdata;
  logic rd;
  srts_ent_t rdata;
  logic rvalid;
  logic rdone;
  logic empty;
  logic ovf;
  logic unf;
  modport fifo(input wr, wdata, rd, output rdata, rvalid, rdone, empty, ovf, unf);
  modport user(output wr, wdata, rd, input rdata, rvalid, rdone, empty, ovf, unf);
endinterface : srts_fifo_if
`default_nettype wire

// ===== core/srts_fifo.sv
// Timestamp FIFO whose entries turn invalid once read.
`include "srts_defs.svh"
`default_nettype none
module srts_fifo (
  input wire logic aclk,
  input wire logic aresetn,
  srts_fifo_if.fifo f
);
  import srts_pkg::*;
  srts_ent_t mem_reg [`SRTS_DEPTH];
  logic [`SRTS_DEPTH-1:0] vld_reg;
  logic [`SRTS_PW-1:0] wp_reg;
  logic [`SRTS_PW-1:0] rp_reg;
  logic [`SRTS_PW:0] cnt_reg;
  srts_ent_t rdata_reg;
  logic rvalid_reg;
  logic rdone_reg;
  logic ovf_reg;
  logic unf_reg;
  wire logic full = cnt_reg == `SRTS_CNT_FULL;
  wire logic empty = cnt_reg == 3'h0;
  wire logic do_wr = f.wr && !full;
  wire logic do_rd = f.rd && !empty;
  wire logic [`SRTS_DEPTH-1:0] wsel = {{(`SRTS_DEPTH-1){1'b0}}, do_wr} << wp_reg;
  wire logic [`SRTS_DEPTH-1:0] rsel = {{(`SRTS_DEPTH-1){1'b0}}, f.rd} << rp_reg;
  wire logic [`SRTS_PW:0] cnt_next = cnt_reg + {2'h0, do_wr} - {2'h0, do_rd};

  // A read on an empty FIFO does not move the pointer, so it returns an invalid entry.
  for (genvar i = 0; i < `SRTS_DEPTH; i++) begin : g_ent
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        mem_reg[i] <= 5'h00;
        vld_reg[i] <= 1'b0;
      end else if (wsel[i]) begin
        mem_reg[i] <= f.wdata;
        vld_reg[i] <= 1'b1;
      end else if (rsel[i]) begin
        mem_reg[i] <= 5'h00;
        vld_reg[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp_reg <= 2'h0;
      rp_reg <= 2'h0;
      cnt_reg <= 3'h0;
    end else begin
      if (do_wr) wp_reg <= wp_reg + 2'h1;
      if (do_rd) rp_reg <= rp_reg + 2'h1;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_reg <= 5'h00;
      rvalid_reg <= 1'b0;
      rdone_reg <= 1'b0;
      ovf_reg <= 1'b0;
      unf_reg <= 1'b0;
    end else begin
      rdone_reg <= f.rd;
      if (f.rd) begin
        rdata_reg <= mem_reg[rp_reg];
        rvalid_reg <= vld_reg[rp_reg];
      end
      ovf_reg <= f.wr && full;
      unf_reg <= f.rd && empty;
    end
  end

  assign f.rdata = rdata_reg;
  assign f.rvalid = rvalid_reg;
  assign f.rdone = rdone_reg;
  assign f.empty = empty;
  assign f.ovf = ovf_reg;
  assign f.unf = unf_reg;

  property p_rd_inval;
    @(posedge aclk) disable iff (!aresetn)
    f.rd && !do_wr |=> !vld_reg[$past(rp_reg)];
  endproperty
  a_rd_inval: assert property (p_rd_inval) else $error("read entry not invalidated");

  property p_depth;
    @(posedge aclk) disable iff (!aresetn)
    cnt_reg <= `SRTS_CNT_FULL;
  endproperty
  a_depth: assert property (p_depth) else $error("fill count beyond depth");
endmodule : srts_fifo
`default_nettype wire

// ===== core/srts_timestamp.sv
// Per-port residual time stamp generation, receive timestamp FIFO and adaptive compare.
//
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`include "srts_defs.svh"
`default_nettype none
module srts_timestamp (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`SRTS_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`SRTS_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic port_line_clock_in,
  input wire logic port_pll_clock,
  input wire logic backplane_clock,
  input wire logic net_clock_div,
  input wire logic seg_req,
  output logic [3:0] seg_rts,
  output logic seg_rts_valid,
  input wire logic rx_rts_wr,
  input wire srts_pkg::srts_ent_t rx_rts,
  input wire logic pll_rts_req,
  output logic [3:0] pll_rts,
  output logic pll_rts_valid,
  output logic [3:0] pll_loc_rts,
  output logic pll_loc_valid,
  output logic pll_holdover,
  input wire srts_pkg::srts_phase_t phaseword,
  output logic rate_up,
  output logic rate_down
);
  import srts_pkg::*;

  logic [`SRTS_CTRL_W-1:0] ctrl_reg;
  logic [`SRTS_STS_W-1:0] sts_reg;
  srts_phase_t avg_reg;
  logic [3:0] edge_prev_reg;
  logic [3:0] net_cnt_reg;
  logic [1:0] gen_pulse;
  logic [3:0] seg_rts_reg;
  logic seg_valid_reg;
  logic [3:0] pll_rts_reg;
  logic pll_valid_reg;
  logic [3:0] loc_rts_reg;
  logic loc_valid_reg;
  logic hold_reg;
  logic up_reg;
  logic dn_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic [`SRTS_AW-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;

  srts_fifo_if txf ();
  srts_fifo_if rxf ();

  srts_fifo u_tx_fifo (.aclk(aclk), .aresetn(aresetn), .f(txf));
  srts_fifo u_rx_fifo (.aclk(aclk), .aresetn(aresetn), .f(rxf));

  wire logic structured_transfer = ctrl_reg[`SRTS_C_SDT];
  wire logic cas = ctrl_reg[`SRTS_C_CAS];
  wire logic adp = ctrl_reg[`SRTS_C_ADP];
  wire srts_src_e src = srts_src_e'(ctrl_reg[`SRTS_C_SRC +: 2]);
  wire logic [5:0] chan_n = ctrl_reg[`SRTS_C_N +: 6];
  wire logic gen_en = !(structured_transfer && cas);

  // Clock pins are sampled as plain inputs; a rising level is one tick.
  wire logic [3:0] pins = {net_clock_div, backplane_clock, port_pll_clock, port_line_clock_in};
  wire logic [3:0] pin_rise = pins & ~edge_prev_reg;
  wire logic line_edge = pin_rise[0];
  wire logic pll_edge = pin_rise[1];
  wire logic bp_edge = pin_rise[2];
  wire logic net_edge = pin_rise[3];

  // The backplane clock is honoured only in structured mode.
  wire logic src_edge = (structured_transfer && src == SRTS_SRC_BP) ? bp_edge :
    (src == SRTS_SRC_PLL) ? pll_edge : line_edge;
  wire logic [1:0] gen_edge = {pll_edge, src_edge};
  wire logic [11:0] lim = structured_transfer ? `SRTS_LIM_SDT : `SRTS_LIM_UDT;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      edge_prev_reg <= 4'h0;
      net_cnt_reg <= 4'h0;
    end else begin
      edge_prev_reg <= pins;
      if (net_edge) net_cnt_reg <= net_cnt_reg + 4'h1;
    end
  end

  // Generator 0 stamps transmit traffic, generator 1 makes local stamps from the PLL.
  for (genvar g = 0; g < 2; g++) begin : g_gen
    logic [4:0] acc_reg;
    logic [11:0] div_reg;
    wire logic [5:0] sum = {1'b0, acc_reg} + chan_n;
    wire logic tick = gen_edge[g] && (!structured_transfer || sum[5]);
    assign gen_pulse[g] = gen_en && tick && div_reg >= lim;
    always_ff @(posedge aclk) begin
      if (!aresetn || !gen_en) begin
        acc_reg <= 5'h00;
        div_reg <= 12'h000;
      end else if (gen_edge[g]) begin
        if (structured_transfer) acc_reg <= sum[4:0];
        if (tick) div_reg <= gen_pulse[g] ? 12'h000 : div_reg + 12'h001;
      end
    end
  end

  assign txf.wr = gen_pulse[0];
  assign txf.wdata = {1'b0, net_cnt_reg};
  assign txf.rd = seg_req;
  assign rxf.wr = rx_rts_wr;
  assign rxf.wdata = rx_rts;
  assign rxf.rd = pll_rts_req;
  wire logic rx_err = rxf.rdata[4];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seg_rts_reg <= 4'h0;
      seg_valid_reg <= 1'b0;
    end else if (txf.rdone) begin
      seg_rts_reg <= txf.rdata[3:0];
      seg_valid_reg <= txf.rvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pll_rts_reg <= 4'h0;
      pll_valid_reg <= 1'b0;
      hold_reg <= 1'b0;
    end else if (rxf.rdone) begin
      pll_rts_reg <= rxf.rdata[3:0];
      pll_valid_reg <= rxf.rvalid && !rx_err;
      hold_reg <= !rxf.rvalid;
    end
  end

  // A new local stamp wins over the discard of the old one.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loc_rts_reg <= 4'h0;
      loc_valid_reg <= 1'b0;
    end else if (gen_pulse[1]) begin
      loc_rts_reg <= net_cnt_reg;
      loc_valid_reg <= 1'b1;
    end else if (rxf.rdone) begin
      loc_valid_reg <= 1'b0;
    end
  end

  // Equal phaseword and average leaves the clock untouched.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      up_reg <= 1'b0;
      dn_reg <= 1'b0;
    end else begin
      up_reg <= adp && phaseword > avg_reg;
      dn_reg <= adp && phaseword < avg_reg;
    end
  end

  // Register bus slave; write address and data are taken in either order.
  wire logic wr_fire = !awready_reg && !wready_reg && !bvalid_reg;
  wire logic [`SRTS_AW-1:0] aw_word = {awaddr_reg[`SRTS_AW-1:2], 2'h0};
  wire logic [`SRTS_AW-1:0] ar_word = {s_axi_araddr[`SRTS_AW-1:2], 2'h0};
  wire logic wr_ctrl = wr_fire && aw_word == `SRTS_OFF_CTRL;
  wire logic wr_sts = wr_fire && aw_word == `SRTS_OFF_STATUS;
  wire logic wr_avg = wr_fire && aw_word == `SRTS_OFF_AVG;
  wire logic wr_hit = wr_ctrl || wr_sts || wr_avg || aw_word == `SRTS_OFF_OBS;
  wire logic [31:0] wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
    {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  wire logic [31:0] ctrl_wide = {21'h000000, ctrl_reg};
  wire logic [31:0] ctrl_merge = (ctrl_wide & ~wmask) | (wdata_reg & wmask);
  wire logic [31:0] avg_merge = ({16'h0000, avg_reg} & ~wmask) | (wdata_reg & wmask);
  wire logic [`SRTS_STS_W-1:0] sts_set = {rxf.unf, rxf.ovf, txf.unf, txf.ovf};
  wire logic [`SRTS_STS_W-1:0] sts_clr = wr_sts ? (wdata_reg[3:0] & wmask[3:0]) : 4'h0;
  wire logic ar_ctrl = ar_word == `SRTS_OFF_CTRL;
  wire logic ar_sts = ar_word == `SRTS_OFF_STATUS;
  wire logic ar_avg = ar_word == `SRTS_OFF_AVG;
  wire logic ar_obs = ar_word == `SRTS_OFF_OBS;
  wire logic [31:0] rd_mux = ar_ctrl ? ctrl_wide :
    ar_sts ? {27'h0000000, hold_reg, sts_reg} :
    ar_avg ? {16'h0000, avg_reg} :
    ar_obs ? {23'h000000, loc_valid_reg, loc_rts_reg, net_cnt_reg} : 32'h00000000;
  wire logic ar_hit = ar_ctrl || ar_sts || ar_avg || ar_obs;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `SRTS_CTRL_RST;
      avg_reg <= 16'h0000;
      sts_reg <= 4'h0;
    end else begin
      if (wr_ctrl) ctrl_reg <= ctrl_merge[`SRTS_CTRL_W-1:0];
      if (wr_avg) avg_reg <= avg_merge[15:0];
      sts_reg <= (sts_reg & ~sts_clr) | sts_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      awaddr_reg <= 5'h00;
    end else if (s_axi_awvalid && awready_reg) begin
      awready_reg <= 1'b0;
      awaddr_reg <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      awready_reg <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_reg <= 1'b1;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else if (s_axi_wvalid && wready_reg) begin
      wready_reg <= 1'b0;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      wready_reg <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `SRTS_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_hit ? `SRTS_RESP_OKAY : `SRTS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `SRTS_RESP_OKAY;
    end else if (s_axi_arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= ar_hit ? `SRTS_RESP_OKAY : `SRTS_RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign seg_rts = seg_rts_reg;
  assign seg_rts_valid = seg_valid_reg;
  assign pll_rts = pll_rts_reg;
  assign pll_rts_valid = pll_valid_reg;
  assign pll_loc_rts = loc_rts_reg;
  assign pll_loc_valid = loc_valid_reg;
  assign pll_holdover = hold_reg;
  assign rate_up = up_reg;
  assign rate_down = dn_reg;

  sequence s_seg_read;
    seg_req && !txf.empty ##1 txf.rdone;
  endsequence
  sequence s_rx_err_read;
    pll_rts_req ##1 rxf.rdone && rx_err && !gen_pulse[1];
  endsequence

  property p_udt_div;
    @(posedge aclk) disable iff (!aresetn)
    gen_pulse[0] && !structured_transfer |-> g_gen[0].div_reg >= `SRTS_LIM_UDT && !cas ##1 g_gen[0].div_reg == 12'h000;
  endproperty
  a_udt_div: assert property (p_udt_div) else $error("unstructured period wrong");

  property p_sdt_div;
    @(posedge aclk) disable iff (!aresetn)
    gen_pulse[0] && structured_transfer |-> g_gen[0].div_reg >= `SRTS_LIM_SDT && g_gen[0].sum[5];
  endproperty
  a_sdt_div: assert property (p_sdt_div) else $error("structured period wrong");

  property p_no_bp;
    @(posedge aclk) disable iff (!aresetn)
    !structured_transfer |-> src_edge == ((src == SRTS_SRC_PLL) ? pll_edge : line_edge);
  endproperty
  a_no_bp: assert property (p_no_bp) else $error("backplane used in unstructured");

  property p_gap;
    @(posedge aclk) disable iff (!aresetn)
    structured_transfer && gen_en && src_edge ##1 structured_transfer && gen_en
      |-> g_gen[0].acc_reg == 5'(({1'b0, $past(g_gen[0].acc_reg)} + chan_n) % 6'h20);
  endproperty
  a_gap: assert property (p_gap) else $error("gapping accumulator wrong");

  property p_tx_cap;
    @(posedge aclk) disable iff (!aresetn)
    gen_pulse[0] |-> txf.wr && txf.wdata[3:0] == net_cnt_reg;
  endproperty
  a_tx_cap: assert property (p_tx_cap) else $error("stamp not captured");

  property p_seg;
    @(posedge aclk) disable iff (!aresetn)
    s_seg_read |=> seg_valid_reg;
  endproperty
  a_seg: assert property (p_seg) else $error("segmenter got no stamp");

  property p_cas;
    @(posedge aclk) disable iff (!aresetn)
    structured_transfer && cas |-> gen_pulse == 2'h0;
  endproperty
  a_cas: assert property (p_cas) else $error("stamp made with signalling");

  property p_err;
    @(posedge aclk) disable iff (!aresetn)
    s_rx_err_read |=> !pll_valid_reg && !loc_valid_reg;
  endproperty
  a_err: assert property (p_err) else $error("errored stamp not discarded");

  property p_hold;
    @(posedge aclk) disable iff (!aresetn)
    pll_rts_req && rxf.empty |-> ##2 hold_reg && !pll_valid_reg;
  endproperty
  a_hold: assert property (p_hold) else $error("no holdover on underrun");

  property p_rx_unf;
    @(posedge aclk) disable iff (!aresetn)
    pll_rts_req && rxf.empty |-> ##2 sts_reg[`SRTS_S_RXUNF];
  endproperty
  a_rx_unf: assert property (p_rx_unf) else $error("rx underrun not flagged");

  property p_tx_ovf;
    @(posedge aclk) disable iff (!aresetn)
    txf.ovf |=> sts_reg[`SRTS_S_TXOVF];
  endproperty
  a_tx_ovf: assert property (p_tx_ovf) else $error("tx overflow not flagged");

  property p_adapt;
    @(posedge aclk) disable iff (!aresetn)
    adp && phaseword > avg_reg |=> up_reg && !dn_reg;
  endproperty
  a_adapt: assert property (p_adapt) else $error("rate not raised above average");
endmodule : srts_timestamp
`default_nettype wire

// ===== verification/srts_partner.sv
// Far-side model: segmenter, reassembler and port PLL request side.
`default_nettype none
module srts_partner (
  input wire logic aclk,
  output logic port_line_clock_in,
  output logic port_pll_clock,
  output logic backplane_clock,
  output logic net_clock_div,
  output logic seg_req,
  output logic rx_rts_wr,
  output srts_pkg::srts_ent_t rx_rts,
  output logic pll_rts_req,
  output srts_pkg::srts_phase_t phaseword
);
  timeunit 1ns;
  timeprecision 1ps;
  import srts_pkg::*;
  initial begin
    {port_line_clock_in, port_pll_clock, net_clock_div, seg_req, rx_rts_wr, pll_rts_req} = 6'h00;
    backplane_clock = 1'b0;
    rx_rts = 5'h00;
    phaseword = 16'h0000;
  end
  // Gives n rising edges on the pins chosen in sel: line, PLL, backplane, network, high bit first.
  task clocks(input int n, input logic [3:0] sel);
    repeat (n) begin
      @(posedge aclk);
      {port_line_clock_in, port_pll_clock, backplane_clock, net_clock_div} <= sel;
      @(posedge aclk);
      {port_line_clock_in, port_pll_clock, backplane_clock, net_clock_div} <= 4'h0;
    end
  endtask : clocks
  // A one-cycle request; returns once the answer has settled.
  task req(input logic pll);
    repeat (4) @(posedge aclk);
    {seg_req, pll_rts_req} <= {!pll, pll};
    @(posedge aclk);
    {seg_req, pll_rts_req} <= 2'h0;
    repeat (2) @(posedge aclk);
    #1;
  endtask : req
  // The data lines show the inverse value once the write strobe is gone.
  task push(input srts_ent_t v);
    @(posedge aclk);
    {rx_rts_wr, rx_rts} <= {1'b1, v};
    @(posedge aclk);
    {rx_rts_wr, rx_rts} <= {1'b0, ~v};
  endtask : push
  task phase(input srts_phase_t v);
    @(posedge aclk);
    phaseword <= v;
    repeat (3) @(posedge aclk);
    #1;
  endtask : phase
endmodule : srts_partner
`default_nettype wire

// ===== verification/srts_timestamp_tb.sv
// Self-checking bench for the residual time stamp block.
`include "srts_defs.svh"
`default_nettype none
module srts_timestamp_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import srts_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, line_clk, pll_clk, bp_clk, net_div, seg_req, rx_wr, pll_req;
  logic [3:0] strb;
  logic seg_v, pll_v, loc_v, hold, up, down;
  logic [`SRTS_AW-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, resp;
  logic [3:0] seg_rts, pll_rts, loc_rts;
  srts_ent_t rx_rts;
  srts_phase_t phaseword;
  int err_count, num_checks;
  srts_timestamp uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .port_line_clock_in(line_clk), .port_pll_clock(pll_clk),
    .backplane_clock(bp_clk), .net_clock_div(net_div), .seg_req(seg_req), .seg_rts(seg_rts),
    .seg_rts_valid(seg_v), .rx_rts_wr(rx_wr), .rx_rts(rx_rts), .pll_rts_req(pll_req),
    .pll_rts(pll_rts), .pll_rts_valid(pll_v), .pll_loc_rts(loc_rts), .pll_loc_valid(loc_v),
    .pll_holdover(hold), .phaseword(phaseword), .rate_up(up), .rate_down(down));
  srts_partner ptn (.aclk(aclk), .port_line_clock_in(line_clk), .port_pll_clock(pll_clk),
    .backplane_clock(bp_clk), .net_clock_div(net_div), .seg_req(seg_req), .rx_rts_wr(rx_wr),
    .rx_rts(rx_rts),
    .pll_rts_req(pll_req), .phaseword(phaseword));
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask : chk
  task end_of_test();
    $display("checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end
    else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  // One register access; each channel is released at its own handshake.
  task bus(input logic w, input logic [`SRTS_AW-1:0] a, input logic [31:0] d);
    @(posedge aclk);
    {awaddr, araddr, wdata} <= {a, a, d};
    {awvalid, wvalid, bready} <= {3{w}};
    {arvalid, rready} <= {2{!w}};
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
    end while ((w ? bvalid : rvalid) !== 1'b1);
    {bready, rready} <= 2'h0;
    rd = rdata;
    resp = w ? bresp : rresp;
  endtask : bus
  task t_regs();
    bus(1'b0, `SRTS_OFF_CTRL, 32'h0);
    chk("ctrl", rd, 32'h0);
    bus(1'b0, `SRTS_OFF_STATUS, 32'h0);
    chk("status", rd, 32'h0);
    bus(1'b1, `SRTS_OFF_AVG, 32'h0000ABCD);
    chk("bresp", {30'h0, resp}, {30'h0, `SRTS_RESP_OKAY});
    strb <= 4'h1;
    bus(1'b1, `SRTS_OFF_AVG, 32'h0000FF12);
    strb <= 4'hF;
    bus(1'b0, `SRTS_OFF_AVG, 32'h0);
    chk("avg", rd, 32'h0000AB12);
    bus(1'b1, 5'h10, 32'h1);
    chk("bresp", {30'h0, resp}, {30'h0, `SRTS_RESP_SLVERR});
    bus(1'b0, 5'h14, 32'h0);
    chk("rresp", {30'h0, resp}, {30'h0, `SRTS_RESP_SLVERR});
    chk("rdata", rd, 32'h0);
  endtask : t_regs
  task t_line();
    ptn.clocks(5, 4'h1);
    ptn.clocks(3008, 4'hC);
    ptn.req(1'b0);
    chk("seg_rts", {28'h0, seg_rts}, 32'h5);
    chk("seg_v", {31'h0, seg_v}, 32'h1);
    chk("loc_rts", {28'h0, loc_rts}, 32'h5);
    chk("loc_v", {31'h0, loc_v}, 32'h1);
    bus(1'b0, `SRTS_OFF_OBS, 32'h0);
    chk("obs", rd, 32'h155);
    ptn.clocks(3007, 4'h8);
    ptn.req(1'b0);
    chk("seg_v", {31'h0, seg_v}, 32'h0);
    bus(1'b0, `SRTS_OFF_STATUS, 32'h0);
    chk("tx_unf", {31'h0, rd[`SRTS_S_TXUNF]}, 32'h1);
    ptn.clocks(1, 4'h8);
    ptn.req(1'b0);
    chk("seg_v", {31'h0, seg_v}, 32'h1);
  endtask : t_line
  task t_rx();
    ptn.push(5'h17);
    ptn.req(1'b1);
    chk("pll_v", {31'h0, pll_v}, 32'h0);
    chk("loc_v", {31'h0, loc_v}, 32'h0);
    ptn.push(5'h03);
    ptn.req(1'b1);
    chk("pll_rts", {27'h0, pll_v, pll_rts}, 32'h13);
    chk("hold", {31'h0, hold}, 32'h0);
    ptn.req(1'b1);
    chk("pll_v", {31'h0, pll_v}, 32'h0);
    chk("hold", {31'h0, hold}, 32'h1);
    for (int i = 1; i <= 5; i++) ptn.push(5'(i));
    bus(1'b0, `SRTS_OFF_STATUS, 32'h0);
    chk("rx_unf", {31'h0, rd[`SRTS_S_RXUNF]}, 32'h1);
    chk("rx_ovf", {31'h0, rd[`SRTS_S_RXOVF]}, 32'h1);
    for (int i = 1; i <= 4; i++) begin
      ptn.req(1'b1);
      chk("pll_rts", {27'h0, pll_v, pll_rts}, 32'h10 + 32'(i));
    end
    ptn.req(1'b1);
    chk("pll_v", {31'h0, pll_v}, 32'h0);
    bus(1'b1, `SRTS_OFF_STATUS, 32'hF);
    bus(1'b0, `SRTS_OFF_STATUS, 32'h0);
    chk("status", rd, 32'h10);
  endtask : t_rx
  task t_gapped();
    int edges;
    edges = (3000 * 32 + 17) / 18;
    ptn.clocks(4, 4'h1);
    bus(1'b1, `SRTS_OFF_CTRL, 32'h403);
    ptn.clocks(3000, 4'h8);
    ptn.req(1'b0);
    chk("seg_v", {31'h0, seg_v}, 32'h0);
    bus(1'b1, `SRTS_OFF_CTRL, 32'h241);
    ptn.clocks(edges - 1, 4'h8);
    ptn.req(1'b0);
    chk("seg_v", {31'h0, seg_v}, 32'h0);
    ptn.clocks(1, 4'h8);
    ptn.req(1'b0);
    chk("seg_rts", {27'h0, seg_v, seg_rts}, 32'h19);
  endtask : t_gapped
  // Backplane edges are ignored unstructured and drive the gapped divider when structured.
  task t_src();
    bus(1'b1, `SRTS_OFF_CTRL, 32'h0C);
    ptn.clocks(3008, 4'h2);
    ptn.req(1'b0);
    chk("seg_v", {31'h0, seg_v}, 32'h0);
    bus(1'b1, `SRTS_OFF_CTRL, 32'h40D);
    ptn.clocks(3000, 4'h2);
    ptn.req(1'b0);
    chk("seg_rts", {27'h0, seg_v, seg_rts}, 32'h19);
  endtask : t_src
  task t_adapt();
    bus(1'b1, `SRTS_OFF_CTRL, 32'h10);
    bus(1'b1, `SRTS_OFF_AVG, 32'h64);
    ptn.phase(16'h00C8);
    chk("rate", {30'h0, up, down}, 32'h2);
    ptn.phase(16'h0032);
    chk("rate", {30'h0, up, down}, 32'h1);
    ptn.phase(16'h0064);
    chk("rate", {30'h0, up, down}, 32'h0);
  endtask : t_adapt
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 42'h0;
    strb = 4'hF;
    err_count = 0;
    num_checks = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_line();
    t_rx();
    t_gapped();
    t_src();
    t_adapt();
    end_of_test();
  end
  initial begin
    repeat (70000) @(posedge aclk);
    err_count++;
    end_of_test();
  end
endmodule : srts_timestamp_tb
`default_nettype wire
